// [rtl/sram_port_pkg.sv]
// Shared constants and types for the synchronous burst static RAM port.
// Assumes one clock domain; all pins but RESETN and OUTPUT_EN_N are sampled on the rising clock edge; SLEEP_REQUEST also turns drivers off at once.
package sram_port_pkg;
    localparam int LANE_W = 9;
    localparam int LANES = 4;
    localparam int WORD_W = LANE_W * LANES;
    localparam int BURST_W = 2;
    localparam int BUF_DEPTH = 2;
    localparam logic [BURST_W-1:0] COUNT_RESET = 2'h0;
    localparam logic [BURST_W-1:0] COUNT_STEP = 2'h1;
    localparam logic [1:0] BUF_EMPTY = 2'h0;
    localparam logic [1:0] BUF_ONE = 2'h1;
    localparam logic [1:0] BUF_FULL = 2'h2;
    localparam logic [LANES-1:0] LANES_IDLE = 4'hf;
    typedef enum logic [2:0] {
        BST_IDLE = 3'b001,
        BST_READ = 3'b010,
        BST_WRITE = 3'b100
    } burst_state_t;
endpackage

// [rtl/sync_burst_sram_port.sv]
// Synchronous burst static RAM with pipelined or flow-through reads and late writes.
// Assumes the host drives all synchronous pins around the rising edge of CLK.
`timescale 1ns/100ps
`default_nettype none

module sync_burst_sram_port #(
    parameter int ADDR_W = 21
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [ADDR_W-3:0] ADDR_HI,
    input wire logic [1:0] BURST_SEED_BITS,
    input wire logic BURST_STEP_SEL,
    input wire logic STORE_REQ_N,
    input wire logic CHIP_SEL_A_N,
    input wire logic CHIP_SEL_B,
    input wire logic CHIP_SEL_C_N,
    input wire logic CLK_GATE_N,
    input wire logic OUTPUT_EN_N,
    input wire logic SLEEP_REQUEST,
    input wire logic FLOW_MODE_SEL_N,
    input wire logic LINEAR_ORDER_SEL_N,
    input wire logic LANE_WRITE_A_N,
    input wire logic LANE_WRITE_B_N,
    input wire logic LANE_WRITE_C_N,
    input wire logic LANE_WRITE_D_N,
    input wire logic [8:0] LANE_A_IN,
    input wire logic [8:0] LANE_B_IN,
    input wire logic [8:0] LANE_C_IN,
    input wire logic [8:0] LANE_D_IN,
    output logic [8:0] LANE_A_OUT,
    output logic [8:0] LANE_B_OUT,
    output logic [8:0] LANE_C_OUT,
    output logic [8:0] LANE_D_OUT,
    output logic LANE_A_OE,
    output logic LANE_B_OE,
    output logic LANE_C_OE,
    output logic LANE_D_OE,
    output logic [35:0] READ_DATA,
    output logic READ_VALID,
    input wire logic READ_READY,
    output logic READ_BUF_READY
);
    localparam int WW = sram_port_pkg::WORD_W;
    localparam int LW = sram_port_pkg::LANE_W;

    typedef struct packed {
        logic act;
        logic wr;
        logic [sram_port_pkg::LANES-1:0] lanes_n;
        logic [ADDR_W-1:0] addr;
    } cmd_t;

    typedef struct packed {
        cmd_t s1;
        cmd_t s2;
        sram_port_pkg::burst_state_t bst;
        logic [ADDR_W-3:0] base_hi;
        logic [1:0] seed;
        logic [1:0] count;
        logic [WW-1:0] q;
        logic drive;
        logic [WW-1:0] buf0;
        logic [WW-1:0] buf1;
        logic [1:0] bcnt;
        logic rvalid;
        logic bready;
    } state_t;

    state_t st;
    state_t next_st;
    logic [WW-1:0] mem [2**ADDR_W];
    logic sel;
    logic hold;
    logic full;
    logic wr_go;
    cmd_t wr_cmd;
    logic [WW-1:0] din;

    // Burst low address bits from seed and count
    function automatic logic [1:0] burst_low(input logic [1:0] seed, input logic [1:0] cnt, input logic lin_n);
        burst_low = lin_n ? (seed ^ cnt) : 2'(seed + cnt);
    endfunction

    // Lane-wise merge of new data over an old word
    function automatic logic [WW-1:0] merge(input logic [WW-1:0] old, input logic [WW-1:0] nw,
                                            input logic [sram_port_pkg::LANES-1:0] lanes_n);
        logic [WW-1:0] r;
        r = old;
        for (int i = 0; i < sram_port_pkg::LANES; i++) begin
            if (!lanes_n[i]) begin
                r[i*LW +: LW] = nw[i*LW +: LW];
            end
        end
        merge = r;
    endfunction

    assign din = {LANE_D_IN, LANE_C_IN, LANE_B_IN, LANE_A_IN};
    assign sel = !CHIP_SEL_A_N && CHIP_SEL_B && !CHIP_SEL_C_N;
    assign full = (st.bcnt == sram_port_pkg::BUF_FULL);
    assign hold = CLK_GATE_N || full;
    // Write data arrives one edge after the command in flow mode, two in pipelined
    assign wr_cmd = FLOW_MODE_SEL_N ? st.s2 : st.s1;
    assign wr_go = !hold && wr_cmd.act && wr_cmd.wr;

    always_comb begin
        cmd_t cmd;
        logic [WW-1:0] rd;
        logic push;
        logic pop;
        logic [1:0] cnt;
        next_st = st;
        cmd = '0;
        rd = '0;
        push = 1'b0;
        cnt = 2'(st.count + sram_port_pkg::COUNT_STEP);
        pop = (st.bcnt != sram_port_pkg::BUF_EMPTY) && READ_READY;
        if (!hold) begin
            if (SLEEP_REQUEST) begin
                next_st.bst = sram_port_pkg::BST_IDLE;
            end else if (!BURST_STEP_SEL) begin
                if (sel) begin
                    next_st.base_hi = ADDR_HI;
                    next_st.seed = BURST_SEED_BITS;
                    next_st.count = sram_port_pkg::COUNT_RESET;
                    cmd.act = 1'b1;
                    cmd.wr = !STORE_REQ_N;
                    cmd.addr = {ADDR_HI, BURST_SEED_BITS};
                    next_st.bst = STORE_REQ_N ? sram_port_pkg::BST_READ : sram_port_pkg::BST_WRITE;
                end else begin
                    next_st.bst = sram_port_pkg::BST_IDLE;
                end
            end else begin
                next_st.count = cnt;
                if (st.bst != sram_port_pkg::BST_IDLE) begin
                    cmd.act = 1'b1;
                    cmd.wr = (st.bst == sram_port_pkg::BST_WRITE);
                    cmd.addr = {st.base_hi, burst_low(st.seed, cnt, LINEAR_ORDER_SEL_N)};
                end
            end
            cmd.lanes_n = {LANE_WRITE_D_N, LANE_WRITE_C_N, LANE_WRITE_B_N, LANE_WRITE_A_N};
            next_st.s1 = cmd;
            next_st.s2 = st.s1;
            if (!FLOW_MODE_SEL_N) begin
                if (cmd.act && !cmd.wr) begin
                    rd = mem[cmd.addr];
                    if (wr_go && wr_cmd.addr == cmd.addr) begin
                        rd = merge(rd, din, wr_cmd.lanes_n);
                    end
                    push = 1'b1;
                end
            end else if (st.s1.act && !st.s1.wr) begin
                rd = mem[st.s1.addr];
                if (wr_go && wr_cmd.addr == st.s1.addr) begin
                    rd = merge(rd, din, wr_cmd.lanes_n);
                end
                push = 1'b1;
            end
            next_st.q = push ? rd : st.q;
            next_st.drive = push;
        end
        case ({push, pop})
            2'b10: begin
                if (st.bcnt == sram_port_pkg::BUF_EMPTY) begin
                    next_st.buf0 = rd;
                end else begin
                    next_st.buf1 = rd;
                end
                next_st.bcnt = 2'(st.bcnt + 2'h1);
            end
            2'b01: begin
                next_st.buf0 = st.buf1;
                next_st.bcnt = 2'(st.bcnt - 2'h1);
            end
            2'b11: begin
                if (st.bcnt == sram_port_pkg::BUF_ONE) begin
                    next_st.buf0 = rd;
                end else begin
                    next_st.buf0 = st.buf1;
                    next_st.buf1 = rd;
                end
            end
            default: begin
                next_st.bcnt = st.bcnt;
            end
        endcase
        next_st.rvalid = (next_st.bcnt != sram_port_pkg::BUF_EMPTY);
        next_st.bready = (next_st.bcnt != sram_port_pkg::BUF_FULL);
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            st <= '0;
            st.bst <= sram_port_pkg::BST_IDLE;
            st.bready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Storage array, written lane by lane
    always_ff @(posedge CLK) begin
        if (wr_go) begin
            for (int i = 0; i < sram_port_pkg::LANES; i++) begin
                if (!wr_cmd.lanes_n[i]) begin
                    mem[wr_cmd.addr][i*LW +: LW] <= din[i*LW +: LW];
                end
            end
        end
    end

    // Drivers off at once on output enable or sleep
    always_comb begin
        logic en;
        en = st.drive && !OUTPUT_EN_N && !SLEEP_REQUEST;
        LANE_A_OE = en;
        LANE_B_OE = en;
        LANE_C_OE = en;
        LANE_D_OE = en;
    end

    assign LANE_A_OUT = st.q[8:0];
    assign LANE_B_OUT = st.q[17:9];
    assign LANE_C_OUT = st.q[26:18];
    assign LANE_D_OUT = st.q[35:27];
    assign READ_DATA = st.buf0;
    assign READ_VALID = st.rvalid;
    assign READ_BUF_READY = st.bready;

    sequence s_read_begin;
        !hold && !SLEEP_REQUEST && !BURST_STEP_SEL && sel && STORE_REQ_N;
    endsequence

    sequence s_advance;
        !hold && FLOW_MODE_SEL_N && !SLEEP_REQUEST;
    endsequence

    property p_pipe_read;
        @(posedge CLK) disable iff (!RESETN)
        (s_read_begin and FLOW_MODE_SEL_N) ##1 s_advance |=> st.drive;
    endproperty
    a_pipe_read: assert property (p_pipe_read) else $error("pipelined read not driven after two edges");

    property p_flow_read;
        @(posedge CLK) disable iff (!RESETN)
        (s_read_begin and !FLOW_MODE_SEL_N) |=> st.drive && st.q == $past(mem[{ADDR_HI, BURST_SEED_BITS}]);
    endproperty
    a_flow_read: assert property (p_flow_read) else $error("flow-through read not driven after one edge");

    property p_oe_off;
        @(posedge CLK) disable iff (!RESETN)
        (OUTPUT_EN_N || SLEEP_REQUEST) |-> !(LANE_A_OE || LANE_B_OE || LANE_C_OE || LANE_D_OE);
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("data drivers on while disabled");

    property p_sleep;
        @(posedge CLK) disable iff (!RESETN)
        (SLEEP_REQUEST && !hold) |=> !st.s1.act && st.bst == sram_port_pkg::BST_IDLE;
    endproperty
    a_sleep: assert property (p_sleep) else $error("access accepted during sleep");

    property p_gate;
        @(posedge CLK) disable iff (!RESETN)
        CLK_GATE_N |=> $stable(st.s1) && $stable(st.count) && $stable(st.q) && $stable(st.drive);
    endproperty
    a_gate: assert property (p_gate) else $error("state changed while clock gated");

    property p_step;
        @(posedge CLK) disable iff (!RESETN)
        (!hold && !SLEEP_REQUEST && BURST_STEP_SEL) |=> st.count == 2'($past(st.count) + 2'h1);
    endproperty
    a_step: assert property (p_step) else $error("burst counter did not advance");

    property p_load;
        @(posedge CLK) disable iff (!RESETN)
        (!hold && !SLEEP_REQUEST && !BURST_STEP_SEL && sel) |=> st.count == 2'h0 && st.seed == $past(BURST_SEED_BITS);
    endproperty
    a_load: assert property (p_load) else $error("burst counter not preloaded");

    property p_deselect;
        @(posedge CLK) disable iff (!RESETN)
        (!hold && !BURST_STEP_SEL && !sel) |=> !st.s1.act ##1 (!st.drive || !FLOW_MODE_SEL_N || $past(hold));
    endproperty
    a_deselect: assert property (p_deselect) else $error("access taken while not selected");

    property p_lane_write;
        @(posedge CLK) disable iff (!RESETN)
        (wr_go && !wr_cmd.lanes_n[0]) |=> mem[$past(wr_cmd.addr)][8:0] == $past(din[8:0]);
    endproperty
    a_lane_write: assert property (p_lane_write) else $error("lane A write lost");
endmodule
`default_nettype wire

// [dv/host_model.sv]
// Host controller model driving the RAM's synchronous pins.
// Assumes the bench calls its tasks; pins change just after rising clk.
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic clk,
    input wire logic flow_n,
    output logic [3:0] addr_hi,
    output logic [1:0] seed,
    output logic step,
    output logic store_n,
    output logic [2:0] sel,
    output logic [3:0] strobe_n,
    output logic [35:0] wdata
);
    initial begin
        addr_hi = 4'h0;
        seed = 2'h0;
        step = 1'b0;
        store_n = 1'b1;
        sel = 3'h7;
        strobe_n = 4'hf;
        wdata = 36'h0;
    end
    // One command edge; data lines show the inverse
    task automatic cmd(input logic s, input logic w_n, input logic [3:0] a, input logic [1:0] sd,
                       input logic [3:0] st, input logic [2:0] cs);
        @(posedge clk);
        step <= s;
        store_n <= w_n;
        addr_hi <= a;
        seed <= sd;
        sel <= cs;
        strobe_n <= st;
        wdata <= ~wdata;
    endtask
    // Deselect edge carrying data d
    task automatic nop(input logic [35:0] d);
        @(posedge clk);
        step <= 1'b0;
        sel <= 3'h7;
        strobe_n <= 4'hf;
        wdata <= d;
    endtask
    // Single write, data on the late edge
    task automatic wr(input logic [3:0] a, input logic [1:0] sd, input logic [3:0] st,
                      input logic [35:0] d, input logic [2:0] cs);
        cmd(1'b0, 1'b0, a, sd, st, cs);
        if (flow_n) begin
            nop(~d);
        end
        nop(d);
        nop(~d);
    endtask
    // Four-word write burst, each word trailing its command edge
    task automatic burst_wr(input logic [3:0] a, input logic [1:0] sd, input logic [35:0] d0);
        int lat;
        lat = flow_n ? 2 : 1;
        for (int i = 0; i < 4 + lat; i++) begin
            @(posedge clk);
            step <= (i > 0 && i < 4);
            store_n <= 1'b0;
            addr_hi <= a;
            seed <= sd;
            sel <= (i == 0) ? 3'h2 : 3'h7;
            strobe_n <= (i < 4) ? 4'h0 : 4'hf;
            if (i >= lat) begin
                wdata <= d0 + 36'(i - lat);
            end
        end
    endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the burst static RAM port.
// Assumes host_model drives synchronous pins; bench drives async and mode pins.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [35:0] W0 = 36'h123456789;
    localparam logic [35:0] LW = W0 | 36'h00003fe00;
    logic CLK, RESETN, CLK_GATE_N, OUTPUT_EN_N, SLEEP_REQUEST, FLOW_MODE_SEL_N, LINEAR_ORDER_SEL_N, READ_READY;
    logic [3:0] a, st, oe;
    logic [1:0] sd;
    logic stp, wn, rv, br;
    logic [2:0] cs;
    logic [35:0] wd, dq, rdat;
    logic [35:0] rq[$];
    int fail_count, n_tests;
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    host_model u_host_model (.clk(CLK), .flow_n(FLOW_MODE_SEL_N), .addr_hi(a), .seed(sd), .step(stp),
        .store_n(wn), .sel(cs), .strobe_n(st), .wdata(wd));
    sync_burst_sram_port #(.ADDR_W(6)) u_sync_burst_sram_port (.CLK(CLK), .RESETN(RESETN), .ADDR_HI(a),
        .BURST_SEED_BITS(sd), .BURST_STEP_SEL(stp), .STORE_REQ_N(wn), .CHIP_SEL_A_N(cs[2]),
        .CHIP_SEL_B(cs[1]), .CHIP_SEL_C_N(cs[0]), .CLK_GATE_N(CLK_GATE_N), .OUTPUT_EN_N(OUTPUT_EN_N),
        .SLEEP_REQUEST(SLEEP_REQUEST), .FLOW_MODE_SEL_N(FLOW_MODE_SEL_N),
        .LINEAR_ORDER_SEL_N(LINEAR_ORDER_SEL_N), .LANE_WRITE_A_N(st[0]), .LANE_WRITE_B_N(st[1]),
        .LANE_WRITE_C_N(st[2]), .LANE_WRITE_D_N(st[3]), .LANE_A_IN(wd[8:0]), .LANE_B_IN(wd[17:9]),
        .LANE_C_IN(wd[26:18]), .LANE_D_IN(wd[35:27]), .LANE_A_OUT(dq[8:0]), .LANE_B_OUT(dq[17:9]),
        .LANE_C_OUT(dq[26:18]), .LANE_D_OUT(dq[35:27]), .LANE_A_OE(oe[0]), .LANE_B_OE(oe[1]),
        .LANE_C_OE(oe[2]), .LANE_D_OE(oe[3]), .READ_DATA(rdat), .READ_VALID(rv), .READ_READY(READ_READY),
        .READ_BUF_READY(br));
    always @(posedge CLK) begin
        if (rv === 1'b1 && READ_READY === 1'b1) begin
            rq.push_back(rdat);
        end
    end
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic pop(input logic [35:0] exp);
        for (int i = 0; i < 12 && rq.size() == 0; i++) @(posedge CLK);
        if (rq.size() == 0) begin
            fail_count++;
            $display("unexpected at %0t: no read word", $time);
            summarize();
        end else begin
            chk_word(rq.pop_front(), exp);
        end
    endtask
    task automatic rd(input logic [3:0] ad, input logic [1:0] s);
        u_host_model.cmd(1'b0, 1'b1, ad, s, 4'hf, 3'h2);
        u_host_model.nop(~wd);
    endtask
    task automatic rst(input logic f_n, input logic l_n);
        @(posedge CLK);
        RESETN <= 1'b0;
        FLOW_MODE_SEL_N <= f_n;
        LINEAR_ORDER_SEL_N <= l_n;
        repeat (16) @(posedge CLK);
        RESETN <= 1'b1;
        rq.delete();
    endtask
    task automatic t_lanes();
        u_host_model.wr(4'h3, 2'h0, 4'h0, W0, 3'h2);
        rd(4'h3, 2'h0);
        pop(W0);
        u_host_model.cmd(1'b0, 1'b1, 4'h3, 2'h0, 4'hf, 3'h2);
        u_host_model.wr(4'h3, 2'h0, 4'hd, 36'hfffffffff, 3'h2);
        pop(W0);
        rd(4'h3, 2'h0);
        pop(LW);
        u_host_model.wr(4'h3, 2'h0, 4'hf, 36'h0, 3'h2);
        rd(4'h3, 2'h0);
        pop(LW);
        $display("Lanes test done");
    endtask
    task automatic t_select();
        u_host_model.wr(4'h5, 2'h0, 4'h0, 36'h0a5a5a5a5, 3'h2);
        for (int i = 0; i < 8; i++) begin
            if (i != 2) u_host_model.wr(4'h5, 2'h0, 4'h0, 36'(i), 3'(i));
        end
        rd(4'h5, 2'h0);
        pop(36'h0a5a5a5a5);
        $display("Select test done");
    endtask
    task automatic t_gate_sleep();
        CLK_GATE_N <= 1'b1;
        u_host_model.wr(4'h5, 2'h0, 4'h0, 36'h1, 3'h2);
        CLK_GATE_N <= 1'b0;
        SLEEP_REQUEST <= 1'b1;
        u_host_model.wr(4'h5, 2'h0, 4'h0, 36'h2, 3'h2);
        SLEEP_REQUEST <= 1'b0;
        OUTPUT_EN_N <= 1'b1;
        rd(4'h5, 2'h0);
        u_host_model.nop(~wd);
        #1 chk_bit(|oe, 1'b0);
        OUTPUT_EN_N <= 1'b0;
        #1 chk_bit(&oe, 1'b1);
        chk_word(dq, 36'h0a5a5a5a5);
        pop(36'h0a5a5a5a5);
        $display("Gate and sleep test done");
    endtask
    task automatic t_burst(input logic [7:0] order);
        u_host_model.burst_wr(4'h1, 2'h0, 36'h0c0);
        u_host_model.cmd(1'b0, 1'b1, 4'h1, 2'h1, 4'hf, 3'h2);
        for (int i = 0; i < 3; i++) u_host_model.cmd(1'b1, 1'b1, 4'h1, 2'h1, 4'hf, 3'h7);
        u_host_model.nop(~wd);
        for (int i = 0; i < 4; i++) pop(36'h0c0 + 36'(order[2*i +: 2]));
        $display("Burst test done");
    endtask
    task automatic t_buffer();
        READ_READY <= 1'b0;
        rd(4'h3, 2'h0);
        rd(4'h1, 2'h0);
        repeat (3) u_host_model.nop(~wd);
        #1 chk_bit(br, 1'b0);
        chk_bit(rv, 1'b1);
        @(posedge CLK);
        READ_READY <= 1'b1;
        pop(LW);
        pop(36'h0c0);
        $display("Buffer test done");
    endtask
    task automatic t_flow();
        u_host_model.wr(4'h7, 2'h2, 4'h0, 36'h987654321, 3'h2);
        rd(4'h7, 2'h2);
        #1 chk_bit(&oe, 1'b1);
        chk_word(dq, 36'h987654321);
        pop(36'h987654321);
        $display("Flow test done");
    endtask
    initial begin
        RESETN = 1'b0;
        CLK_GATE_N = 1'b0;
        OUTPUT_EN_N = 1'b0;
        SLEEP_REQUEST = 1'b0;
        FLOW_MODE_SEL_N = 1'b1;
        LINEAR_ORDER_SEL_N = 1'b0;
        READ_READY = 1'b1;
        fail_count = 0;
        n_tests = 0;
        rst(1'b1, 1'b0);
        t_lanes();
        t_select();
        t_gate_sleep();
        t_burst(8'h39);
        t_buffer();
        rst(1'b1, 1'b1);
        t_burst(8'hb1);
        rst(1'b0, 1'b0);
        t_flow();
        summarize();
    end
endmodule
`default_nettype wire
